// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import tpp_pkg::*;
;
  logic       mclk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat;
  logic       ack, dOe, irq;
  logic [2:0] pIn, pOut, pOe, r, l, e;
  logic [7:0] dIn, dOut, b, got;
  int         err_total = 0, n_checks = 0, seed = 32'h5F7B, i;
  tpp_port u_tpp_port (.mclk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pinIn(pIn), .pinOut(pOut),
    .pinOe(pOe), .dataIn(dIn), .dataOut(dOut), .dataOe(dOe), .irq);
  tpp_host_model host (.mclk, .pinOut(pOut), .pinOe(pOe), .dataOut(dOut), .dataOe(dOe),
    .pinIn(pIn), .dataIn(dIn));
  initial forever #2 mclk = ~mclk;
  //====
  // Tasks
  task automatic test_done;
    if (err_total == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [7:0] g, x);
    n_checks++;
    if (g !== x)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
    int k;
    @(posedge mclk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, d};
    for (k = 0; k < 50 && ack !== 1'b1; k++)
      @(posedge mclk);
    got = rdat[7:0];
    {cyc, stb} <= 2'b00;
    if (k == 50)
    begin
      err_total++;
      $display("BAD ack exp 1 got 0");
      test_done();
    end
  endtask : wb
  task automatic rc(input string n, input logic [5:0] a, input logic [7:0] x);
    wb(1'b0, a, 8'h00);
    chk(n, got, x);
  endtask : rc
  function automatic logic [7:0] lvl(input logic [2:0] dr, lt, ex);
    return {5'h00, (~dr & lt) | (dr & ex)};
  endfunction : lvl
  //====
  // Sequence
  initial
  begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rc("dir", 6'(OFS_DIRCTL), 8'h07);
    rc("lvl", 6'(OFS_PIN_LEVEL), 8'h00);
    rc("spare", 6'h1C, 8'h00);
    wb(1'b1, 6'(OFS_ANALOG), 8'h07);
    for (i = 0; i < 8; i++)
    begin
      {r, l, e} = 9'($random(seed));
      host.ext <= e;
      wb(1'b1, 6'(OFS_DIRCTL), {5'h00, r});
      wb(1'b1, 6'(OFS_LATCH), {5'h00, l});
      repeat (4) @(posedge mclk);
      rc("latch", 6'(OFS_LATCH), {5'h00, l});
      rc("lvl", 6'(OFS_PIN_LEVEL), lvl(r, l, e));
    end
    host.ext <= 3'h7;
    wb(1'b1, 6'(OFS_DIRCTL), 8'h17);
    wb(1'b1, OFS_IRQ_MASK, 8'h07);
    b = 8'($random(seed));
    host.hwr(~b, 1'b1);
    rc("dir", 6'(OFS_DIRCTL), 8'h17);
    host.hwr(b, 1'b0);
    chk("irq", {7'h00, irq}, 8'h01);
    rc("dir", 6'(OFS_DIRCTL), 8'h97);
    rc("stat", OFS_IRQ_STAT, 8'h01);
    rc("data", OFS_DATA_PORT, b);
    rc("dir", 6'(OFS_DIRCTL), 8'h17);
    host.hwr(b, 1'b0);
    host.hwr(~b, 1'b0);
    rc("dir", 6'(OFS_DIRCTL), 8'hB7);
    wb(1'b1, 6'(OFS_DIRCTL), 8'h17);
    rc("dir", 6'(OFS_DIRCTL), 8'h97);
    rc("stat", OFS_IRQ_STAT, 8'h05);
    repeat (2) @(posedge mclk);
    chk("irq", {7'h00, irq}, 8'h00);
    wb(1'b0, OFS_DATA_PORT, 8'h00);
    wb(1'b1, OFS_DATA_PORT, ~b);
    rc("dir", 6'(OFS_DIRCTL), 8'h57);
    host.hrd(got);
    chk("host", got, ~b);
    rc("dir", 6'(OFS_DIRCTL), 8'h17);
    wb(1'b1, OFS_IRQ_MASK, 8'h00);
    test_done();
  end
endmodule : tb_top

// >>> bench/tpp_host_model.sv
`timescale 1ns/1ps
module tpp_host_model
(
  // Clock and pins
  input  wire logic       mclk,
  input  wire logic [2:0] pinOut,
  input  wire logic [2:0] pinOe,
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe,
  output logic      [2:0] pinIn,
  output logic      [7:0] dataIn
);
  logic [2:0] ext = 3'h7;
  logic [7:0] bus = 8'h00;
  assign pinIn  = (pinOe & pinOut) | (~pinOe & ext);
  assign dataIn = dataOe ? dataOut : bus;
  task automatic hwr(input logic [7:0] b, input logic csN);
    @(posedge mclk);
    bus <= b;
    ext <= {csN, 2'b01};
    repeat (6) @(posedge mclk);
    ext <= 3'h7;
    // Released bus shows the inverse so a stale byte cannot pass
    bus <= ~b;
    repeat (6) @(posedge mclk);
  endtask : hwr
  task automatic hrd(output logic [7:0] b);
    @(posedge mclk);
    ext <= 3'b010;
    repeat (6) @(posedge mclk);
    b = dataOut;
    ext <= 3'h7;
    repeat (6) @(posedge mclk);
  endtask : hrd
endmodule : tpp_host_model

// >>> bench/tpp_port_sva.sv
`timescale 1ns/1ps
module tpp_port_sva
  import tpp_pkg::*;
(
  // Clock, reset and bus
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Pins
  input wire logic [2:0]  pinIn,
  input wire logic [2:0]  pinOe,
  input wire logic        dataOe,
  input wire logic        irq
);
  //====
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic rdA = wb_ack_o && !wb_we_i;
  wire logic wrA = wb_ack_o && wb_we_i;
  ack_once_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_resp_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  dir_drive_a:
    assert property (wrA && wb_adr_i == 6'(OFS_DIRCTL) |=> pinOe == ~$past(wb_dat_i[2:0]))
      else $error("pinOe not per dir");
  mask_quiet_a:
    assert property (wrA && wb_adr_i == OFS_IRQ_MASK && wb_dat_i[2:0] == 3'h0 |=> !irq)
      else $error("irq while masked");
  unmapped_zero_a:
    assert property (rdA && wb_adr_i == 6'h1C |-> wb_dat_o == 32'h0) else $error("spare not 0");
  bit3_zero_a:
    assert property (rdA && wb_adr_i == 6'(OFS_DIRCTL) |-> !wb_dat_o[3]) else $error("bit3 set");
  latch_width_a:
    assert property (rdA && wb_adr_i == 6'(OFS_LATCH) |-> wb_dat_o[7:3] == 5'h00)
      else $error("latch too wide");
  read_drive_a:
    assert property ($rose(dataOe) |-> ($past(pinIn, 3) & 3'h5) == 3'h0)
      else $error("drive without read");
endmodule : tpp_port_sva

bind tpp_port tpp_port_sva u_sva (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .pinIn, .pinOe, .dataOe, .irq);

// >>> verilog/tpp_pkg.sv
//==========================================================
package tpp_pkg;

  //==========================================================
  // Register word offsets (byte addresses)
  localparam logic [3:0] OFS_PIN_LEVEL  = 4'h0;
  localparam logic [3:0] OFS_LATCH      = 4'h4;
  localparam logic [3:0] OFS_DIRCTL     = 4'h8;
  localparam logic [3:0] OFS_ANALOG     = 4'hC;
  localparam logic [5:0] OFS_DATA_PORT  = 6'h10;
  localparam logic [5:0] OFS_IRQ_STAT   = 6'h14;
  localparam logic [5:0] OFS_IRQ_MASK   = 6'h18;

  //==========================================================
  // Field positions and reset values
  localparam int BIT_INFULL  = 7;
  localparam int BIT_OUTFULL = 6;
  localparam int BIT_INOVF   = 5;
  localparam int BIT_MODE    = 4;
  localparam logic [2:0] DIR_RESET    = 3'h7;
  localparam logic [3:0] ANALOG_RESET = 4'h0;
  localparam logic [3:0] ANALOG_ALLDIG = 4'h7;
  localparam logic [2:0] ZERO3        = 3'h0;
  localparam logic [7:0] ZERO8        = 8'h00;

  // Interrupt status bits: host wrote, host read, overflow
  localparam int IRQ_HOSTWR = 0;
  localparam int IRQ_HOSTRD = 1;
  localparam int IRQ_OVF    = 2;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b01,
    ACC_BUSY = 2'b10
  } tpp_acc_t;

  typedef struct packed {
    logic        hostRd;
    logic        hostWr;
  } tpp_evt_t;

  typedef struct packed {
    logic [1:0]  pinMeta;
    logic [2:0]  pinSync0;
    logic [2:0]  pinSync1;
    logic [7:0]  dataMeta;
    logic [7:0]  dataSync;
    logic [2:0]  dir_reg;
    logic [2:0]  latch_reg;
    logic [3:0]  analog_reg;
    logic        mode_reg;
    logic        inFull_reg;
    logic        outFull_reg;
    logic        inOvf_reg;
    logic [7:0]  inData_reg;
    logic [7:0]  outData_reg;
    tpp_acc_t    rdAcc;
    tpp_acc_t    wrAcc;
    logic [2:0]  irqStat_reg;
    logic [2:0]  irqMask_reg;
    logic        irq_reg;
    logic        ack_reg;
    logic [31:0] dat_reg;
    logic [2:0]  pinOut_reg;
    logic [2:0]  pinOe_reg;
    logic [7:0]  dOut_reg;
    logic        dOe_reg;
  } tpp_state_t;

  // Pins 0..2 are analog unless the config field selects all digital
  function automatic logic [2:0] tpp_analog_mask(input logic [3:0] cfg);
    tpp_analog_mask = (cfg[2:0] == ANALOG_ALLDIG[2:0]) ? ZERO3 : DIR_RESET;
  endfunction : tpp_analog_mask

endpackage : tpp_pkg

// >>> verilog/tpp_port.sv
`timescale 1ns/1ps
module tpp_port
  import tpp_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Three port pins
  input  wire logic [2:0]  pinIn,
  output logic      [2:0]  pinOut,
  output logic      [2:0]  pinOe,
  // Eight-bit data pins of the slave port
  input  wire logic [7:0]  dataIn,
  output logic      [7:0]  dataOut,
  output logic             dataOe,
  // Interrupt
  output logic             irq
);

  tpp_state_t s, n;
  logic       wbReq;
  logic       wbWr;
  logic       wbRd;
  logic [2:0] anaMask;
  logic [2:0] lvl;
  logic       selLow;
  logic       rdLow;
  logic       wrLow;
  tpp_evt_t   ev;
  logic [2:0] irqSet;

  //==========================================================
  // Next state
  always_comb
  begin
    n       = s;
    wbReq   = wb_cyc_i && wb_stb_i && !s.ack_reg;
    wbWr    = wbReq && wb_we_i && wb_sel_i[0];
    wbRd    = wbReq && !wb_we_i;
    anaMask = tpp_analog_mask(s.analog_reg);
    lvl     = s.pinSync1 & ~anaMask;
    // Strobes only act in slave port mode
    selLow  = s.mode_reg && !s.pinSync1[2];
    rdLow   = selLow && !s.pinSync1[0];
    wrLow   = selLow && !s.pinSync1[1];
    ev      = '{hostRd: 1'b0, hostWr: 1'b0};

    // Two-flop synchronisers; only the second stage is read
    n.pinSync0 = pinIn;
    n.pinSync1 = s.pinSync0;
    n.dataMeta = dataIn;
    n.dataSync = s.dataMeta;
    n.pinMeta  = s.pinMeta;

    // Edge of the combined strobe: one access per assertion
    case (s.wrAcc)
      ACC_IDLE:
      begin
        if (wrLow)
        begin
          ev.hostWr = 1'b1;
          n.wrAcc   = ACC_BUSY;
        end
      end
      ACC_BUSY:
      begin
        if (!wrLow)
          n.wrAcc = ACC_IDLE;
      end
      default: n.wrAcc = ACC_IDLE;
    endcase
    case (s.rdAcc)
      ACC_IDLE:
      begin
        if (rdLow)
        begin
          ev.hostRd = 1'b1;
          n.rdAcc   = ACC_BUSY;
        end
      end
      ACC_BUSY:
      begin
        if (!rdLow)
          n.rdAcc = ACC_IDLE;
      end
      default: n.rdAcc = ACC_IDLE;
    endcase

    // Bus answer: one-cycle ack, unmapped reads return zero
    n.ack_reg = wbReq;
    n.dat_reg = 32'h0000_0000;
    if (wbRd)
    begin
      case (wb_adr_i)
        {2'b00, OFS_PIN_LEVEL}: n.dat_reg[2:0] = lvl;
        {2'b00, OFS_LATCH}:     n.dat_reg[2:0] = s.latch_reg;
        {2'b00, OFS_DIRCTL}:    n.dat_reg[7:0] = {s.inFull_reg, s.outFull_reg, s.inOvf_reg, s.mode_reg,
                                                   1'b0, s.dir_reg};
        {2'b00, OFS_ANALOG}:    n.dat_reg[3:0] = s.analog_reg;
        OFS_DATA_PORT:          n.dat_reg[7:0] = s.inData_reg;
        OFS_IRQ_STAT:           n.dat_reg[2:0] = s.irqStat_reg;
        OFS_IRQ_MASK:           n.dat_reg[2:0] = s.irqMask_reg;
        default:                n.dat_reg = 32'h0000_0000;
      endcase
    end

    // Software writes
    if (wbWr)
    begin
      case (wb_adr_i)
        {2'b00, OFS_PIN_LEVEL},
        {2'b00, OFS_LATCH}:  n.latch_reg = wb_dat_i[2:0];
        {2'b00, OFS_DIRCTL}:
        begin
          n.dir_reg  = wb_dat_i[2:0];
          n.mode_reg = wb_dat_i[BIT_MODE];
          if (!wb_dat_i[BIT_INOVF])
            n.inOvf_reg = 1'b0;
        end
        {2'b00, OFS_ANALOG}: n.analog_reg = wb_dat_i[3:0];
        OFS_DATA_PORT:
        begin
          n.outData_reg = wb_dat_i[7:0];
          n.outFull_reg = 1'b1;
        end
        OFS_IRQ_MASK:        n.irqMask_reg = wb_dat_i[2:0];
        default:             n.pinMeta = s.pinMeta;
      endcase
    end

    // Processor read of the data port empties the input buffer
    if (wbRd && wb_adr_i == OFS_DATA_PORT)
      n.inFull_reg = 1'b0;

    // Host side events win over software clears
    if (ev.hostWr)
    begin
      if (s.inFull_reg)
        n.inOvf_reg = 1'b1;
      n.inFull_reg = 1'b1;
      n.inData_reg = s.dataSync;
    end
    // A new word written in the same cycle keeps the flag set
    if (ev.hostRd && !(wbWr && wb_adr_i == OFS_DATA_PORT))
      n.outFull_reg = 1'b0;

    // Sticky status, cleared by reading it; a new event wins
    irqSet = {ev.hostWr && s.inFull_reg, ev.hostRd, ev.hostWr};
    if (wbRd && wb_adr_i == OFS_IRQ_STAT)
      n.irqStat_reg = irqSet;
    else
      n.irqStat_reg = s.irqStat_reg | irqSet;
    n.irq_reg = |(n.irqStat_reg & s.irqMask_reg);

    // Pin drivers: direction gates the driver even on analog pins
    n.pinOe_reg  = ~s.dir_reg;
    n.pinOut_reg = s.latch_reg & ~s.dir_reg;
    // Data bus driven while host reads
    n.dOe_reg  = rdLow;
    n.dOut_reg = rdLow ? s.outData_reg : ZERO8;
  end

  //==========================================================
  // State register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s             <= '0;
      s.dir_reg     <= DIR_RESET;
      s.analog_reg  <= ANALOG_RESET;
      s.pinSync0    <= DIR_RESET;
      s.pinSync1    <= DIR_RESET;
      s.rdAcc       <= ACC_IDLE;
      s.wrAcc       <= ACC_IDLE;
    end
    else
      s <= n;
  end

  //==========================================================
  // Outputs straight from flops
  assign wb_dat_o = s.dat_reg;
  assign wb_ack_o = s.ack_reg;
  assign pinOut   = s.pinOut_reg;
  assign pinOe    = s.pinOe_reg;
  assign dataOut  = s.dOut_reg;
  assign dataOe   = s.dOe_reg;
  assign irq      = s.irq_reg;

endmodule : tpp_port
